// File: btcc_pkg.sv
// Constants and types for the bus transaction cycle cost timer
package btcc_pkg;

  // Bus timing ratio of the bus clock against the processor clock
  typedef enum logic [1:0] {
    BTCC_R1X = 2'h0,
    BTCC_R2X = 2'h1,
    BTCC_R4X = 2'h2
  } btcc_ratio_t;

  // Kind of bus transaction being costed
  typedef enum logic [4:0] {
    BTCC_RD_BYTE  = 5'h00,
    BTCC_RD_WORD  = 5'h01,
    BTCC_WR_BYTE  = 5'h02,
    BTCC_WR_WORD  = 5'h03,
    BTCC_IO_RD    = 5'h04,
    BTCC_IO_WR    = 5'h05,
    BTCC_TEST_SET = 5'h06,
    BTCC_TMPL_FIRST = 5'h07,
    BTCC_EPU_IFN  = 5'h08,
    BTCC_EPU_CPU  = 5'h09,
    BTCC_EPU_WR   = 5'h0a,
    BTCC_EPU_RD   = 5'h0b,
    BTCC_ACK_NMI  = 5'h0c,
    BTCC_ACK_M0   = 5'h0d,
    BTCC_ACK_M1   = 5'h0e,
    BTCC_ACK_M2   = 5'h0f,
    BTCC_ACK_M3   = 5'h10
  } btcc_kind_t;

  // Operand addressing mode, which adds address computation cycles
  typedef enum logic [2:0] {
    BTCC_AM_IR = 3'h0,
    BTCC_AM_DA = 3'h1,
    BTCC_AM_X  = 3'h2,
    BTCC_AM_SX = 3'h3,
    BTCC_AM_RA = 3'h4,
    BTCC_AM_SR = 3'h5,
    BTCC_AM_BX = 3'h6
  } btcc_amode_t;

  // Widths
  localparam int BTCC_WAIT_W = 4;
  localparam int BTCC_COST_W = 8;

  // Fixed costs, same at every ratio
  localparam logic [7:0] BTCC_C_HIT = 8'h05;
  localparam logic [7:0] BTCC_C_UHH = 8'h09;
  localparam logic [7:0] BTCC_C_FIXED = 8'h06;
  localparam logic [7:0] BTCC_C_FAULT = 8'h04;
  localparam logic [7:0] BTCC_C_NMI = 8'h04;
  localparam logic [7:0] BTCC_C_UWR_FIRST = 8'h0a;
  localparam logic [3:0] BTCC_UWR_FIRST_MAXW = 4'h1;

  // Base costs at 1x, 2x and 4x, before wait and phase terms
  localparam logic [7:0] BTCC_B_MISS [3] = '{8'h08, 8'h0b, 8'h10};
  localparam logic [7:0] BTCC_B_UM1 [3] = '{8'h0c, 8'h0f, 8'h14};
  localparam logic [7:0] BTCC_B_UMM [3] = '{8'h0f, 8'h15, 8'h1f};
  localparam logic [7:0] BTCC_B_UWR [3] = '{8'h09, 8'h0c, 8'h11};
  localparam logic [7:0] BTCC_B_IORD [3] = '{8'h09, 8'h0d, 8'h14};
  localparam logic [7:0] BTCC_B_ECPU [3] = '{8'h09, 8'h0d, 8'h14};
  localparam logic [7:0] BTCC_B_EWR [3] = '{8'h0a, 8'h0f, 8'h18};
  localparam logic [7:0] BTCC_B_ACK0 [3] = '{8'h08, 8'h0d, 8'h16};
  localparam logic [7:0] BTCC_B_ACKN [3] = '{8'h0a, 8'h0f, 8'h18};

  // Address computation cycles
  localparam logic [7:0] BTCC_AM_ADD_NONE = 8'h00;
  localparam logic [7:0] BTCC_AM_ADD_IDX = 8'h01;
  localparam logic [7:0] BTCC_AM_ADD_BX = 8'h02;

  // Reset values and the phase saturation limit
  localparam logic [7:0] BTCC_CNT_RST = 8'h00;
  localparam logic [1:0] BTCC_PHASE_RST = 2'h0;
  localparam logic [1:0] BTCC_PHASE_MAX = 2'h3;

endpackage

// File: btcc_phase.sv
// Bus clock phase tracker for the cost timer
`timescale 1ns/1ps
module btcc_phase (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Bus clock pin, asynchronous to clk
  input wire logic bus_clk,
  // Processor cycles since the last bus clock rise, saturating
  output logic [1:0] phase
);
  import btcc_pkg::*;

  // All state of the tracker
  typedef struct packed {
    logic s1;        // First synchroniser stage
    logic s2;        // Second synchroniser stage
    logic s3;        // Delayed copy for edge detect
    logic [1:0] ph;  // Cycles since rise
  } btcc_ph_t;

  btcc_ph_t r_q;
  btcc_ph_t r_d;

  // Next state: edge detect only looks past the first stage
  always_comb begin
    r_d = r_q;
    r_d.s1 = bus_clk;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    if (r_q.s2 && !r_q.s3) begin
      // Rising bus clock restarts the phase count
      r_d.ph = BTCC_PHASE_RST;
    end else if (r_q.ph != BTCC_PHASE_MAX) begin
      r_d.ph = r_q.ph + 2'h1;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  assign phase = r_q.ph;

endmodule // btcc_phase

// File: btcc_cost_timer.sv
// Bus transaction cycle cost timer: costs and times one transaction
//
// Contract
// - Byte/aligned read: hit 5, miss by ratio
// - Unaligned read, both bytes hit: 9
// - Unaligned read, one byte misses: by ratio
// - Unaligned read, both miss: by ratio
// - Page fault: 4 cycles, then violation trap
// - Aligned only if even and 16-bit bus
// - Address mode adds 0, 1 or 2
// - Byte/aligned write 5; unaligned by ratio
// - Write to valid cached byte flushes pipeline
// - Unaligned write, first byte cached, at 1x: 10 or 9+w
// - Phase extra follows request against bus clock
// - Wait count excludes built-in wait states
// - I/O read by ratio; I/O write 5
// - Internal I/O: 5, no bus cycle
// - Coprocessor transfers cost by ratio
// - Waits count on top of automatic ones
`timescale 1ns/1ps
module btcc_cost_timer (
  // Clock, reset and enable
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  // Bus clock pin, used only for its phase
  input wire logic BUS_CLK,
  // Transaction request, sampled when idle
  input wire logic REQ,
  input wire btcc_pkg::btcc_kind_t REQ_KIND,
  input wire btcc_pkg::btcc_ratio_t REQ_RATIO,
  input wire logic [3:0] REQ_WAIT,
  input wire btcc_pkg::btcc_amode_t REQ_AMODE,
  // Cache state of the first and second byte
  input wire logic REQ_HIT0,
  input wire logic REQ_HIT1,
  // Address bit 0 and bus width
  input wire logic REQ_ADDR0,
  input wire logic REQ_BUS16,
  // Page fault, fixed memory, internal I/O qualifiers
  input wire logic REQ_FAULT,
  input wire logic REQ_FIXED,
  input wire logic REQ_INTERNAL,
  // Status and results
  output logic BUSY,
  output logic DONE,
  output logic [7:0] COST,
  output logic FLUSH,
  output logic AV_TRAP,
  output logic EXT_CYCLE
);
  import btcc_pkg::*;

  // Sequencer states
  typedef enum logic [0:0] {
    BTCC_IDLE = 1'b0,
    BTCC_RUN  = 1'b1
  } btcc_state_t;

  // All state of the timer
  typedef struct packed {
    btcc_state_t st;     // Sequencer state
    logic [7:0] cnt;     // Cycles left minus one
    logic [7:0] cost;    // Cost of the current transaction
    logic fl_pend;       // Flush due at completion
    logic tr_pend;       // Trap due at completion
    logic busy;          // Transaction in progress
    logic done;          // Completion pulse
    logic flush;         // Pipeline flush pulse
    logic trap;          // Access violation trap pulse
    logic ext;           // External bus cycle in use
  } btcc_st_t;

  btcc_st_t r_q;
  btcc_st_t r_d;

  logic [1:0] phase;      // Processor cycles since bus clock rise
  logic aligned;          // Word counts as aligned
  logic is_word;          // Transfer is a word
  logic is_write;         // Transfer is a data write
  logic [7:0] wterm;      // Wait term scaled by ratio
  logic [7:0] xterm;      // Single phase extra
  logic [7:0] amadd;      // Address computation cycles
  logic [7:0] cost_c;     // Computed cost
  logic flush_c;          // Computed flush
  logic ext_c;            // Computed external cycle flag

  // Phase of the bus clock against the processor clock
  btcc_phase u_phase (
    .clk(CLOCK),
    .rst_b(RST_B),
    .ce(CE),
    .bus_clk(BUS_CLK),
    .phase(phase)
  );

  // Ratio index into the base tables; an unused code counts as 1x
  function automatic int unsigned rix(input btcc_ratio_t r);
    case (r)
      BTCC_R2X: rix = 1;
      BTCC_R4X: rix = 2;
      default: rix = 0;
    endcase
  endfunction

  // Base plus scaled waits plus phase extra, used by many kinds
  function automatic logic [7:0] bus_cost(
    input logic [7:0] base [3],
    input btcc_ratio_t r,
    input logic [7:0] w,
    input logic [7:0] x
  );
    bus_cost = base[rix(r)] + w + x;
  endfunction

  // Word alignment: even address over a 16-bit bus only
  always_comb begin
    aligned = !REQ_ADDR0 && REQ_BUS16;
  end

  // Wait states scale with ratio; the requester supplies only the
  // added waits, so the built-in I/O wait never enters here
  always_comb begin
    case (REQ_RATIO)
      BTCC_R2X: wterm = {3'h0, REQ_WAIT, 1'b0};
      BTCC_R4X: wterm = {2'h0, REQ_WAIT, 2'h0};
      default: wterm = {4'h0, REQ_WAIT};
    endcase
  end

  // Phase extra: 0-1 at 2x, 0-3 at 4x, none at 1x. The tracker
  // restarts on each bus clock rise, so the extra really wanders
  always_comb begin
    case (REQ_RATIO)
      BTCC_R2X: xterm = {7'h00, phase[0]};
      BTCC_R4X: xterm = {6'h00, phase};
      default: xterm = BTCC_CNT_RST;
    endcase
  end

  // Address computation cycles, only for memory data transfers
  always_comb begin
    case (REQ_AMODE)
      BTCC_AM_X, BTCC_AM_SX, BTCC_AM_RA, BTCC_AM_SR: begin
        amadd = BTCC_AM_ADD_IDX;
      end
      BTCC_AM_BX: begin
        amadd = BTCC_AM_ADD_BX;
      end
      default: begin
        amadd = BTCC_AM_ADD_NONE;
      end
    endcase
  end

  // Cost table by kind; word flags feed the flush decision
  always_comb begin
    is_word = (REQ_KIND == BTCC_RD_WORD) || (REQ_KIND == BTCC_WR_WORD);
    is_write = (REQ_KIND == BTCC_WR_BYTE) || (REQ_KIND == BTCC_WR_WORD);
    cost_c = BTCC_C_HIT;
    ext_c = 1'b0;
    case (REQ_KIND)
      BTCC_RD_BYTE: begin
        // Byte read behaves like an aligned word
        if (!REQ_HIT0) begin
          cost_c = bus_cost(BTCC_B_MISS, REQ_RATIO, wterm, xterm);
          ext_c = 1'b1;
        end
      end
      BTCC_RD_WORD: begin
        if (aligned) begin
          if (!REQ_HIT0) begin
            cost_c = bus_cost(BTCC_B_MISS, REQ_RATIO, wterm, xterm);
            ext_c = 1'b1;
          end
        end else if (REQ_HIT0 && REQ_HIT1) begin
          cost_c = BTCC_C_UHH;
        end else if (REQ_HIT0 || REQ_HIT1) begin
          cost_c = bus_cost(BTCC_B_UM1, REQ_RATIO, wterm, xterm);
          ext_c = 1'b1;
        end else begin
          // Two bus cycles, so the phase extra can occur twice
          cost_c = bus_cost(BTCC_B_UMM, REQ_RATIO, wterm,
                            {xterm[6:0], 1'b0});
          ext_c = 1'b1;
        end
      end
      BTCC_WR_BYTE: begin
        cost_c = BTCC_C_HIT;
        ext_c = 1'b1;
      end
      BTCC_WR_WORD: begin
        ext_c = 1'b1;
        if (aligned) begin
          cost_c = BTCC_C_HIT;
        end else if (REQ_HIT0 && rix(REQ_RATIO) == 0) begin
          // First byte cached: short waits still cost the full 10
          if (REQ_WAIT <= BTCC_UWR_FIRST_MAXW) begin
            cost_c = BTCC_C_UWR_FIRST;
          end else begin
            cost_c = bus_cost(BTCC_B_UWR, REQ_RATIO, wterm, xterm);
          end
        end else begin
          cost_c = bus_cost(BTCC_B_UWR, REQ_RATIO, wterm, xterm);
        end
      end
      BTCC_IO_RD: begin
        if (REQ_INTERNAL) begin
          cost_c = BTCC_C_HIT;
        end else begin
          cost_c = bus_cost(BTCC_B_IORD, REQ_RATIO, wterm, xterm);
          ext_c = 1'b1;
        end
      end
      BTCC_IO_WR: begin
        // Posted write: fixed cost either way, bus only if external
        cost_c = BTCC_C_HIT;
        ext_c = !REQ_INTERNAL;
      end
      BTCC_TEST_SET: begin
        if (REQ_FIXED) begin
          cost_c = BTCC_C_FIXED;
        end else begin
          cost_c = bus_cost(BTCC_B_MISS, REQ_RATIO, wterm, xterm);
          ext_c = 1'b1;
        end
      end
      BTCC_TMPL_FIRST, BTCC_EPU_IFN, BTCC_EPU_RD: begin
        cost_c = bus_cost(BTCC_B_MISS, REQ_RATIO, wterm, xterm);
        ext_c = 1'b1;
      end
      BTCC_EPU_CPU: begin
        cost_c = bus_cost(BTCC_B_ECPU, REQ_RATIO, wterm, xterm);
        ext_c = 1'b1;
      end
      BTCC_EPU_WR: begin
        cost_c = bus_cost(BTCC_B_EWR, REQ_RATIO, wterm, xterm);
        ext_c = 1'b1;
      end
      BTCC_ACK_NMI: begin
        cost_c = BTCC_C_NMI;
      end
      BTCC_ACK_M0: begin
        cost_c = bus_cost(BTCC_B_ACK0, REQ_RATIO, wterm, xterm);
        ext_c = 1'b1;
      end
      BTCC_ACK_M1, BTCC_ACK_M2, BTCC_ACK_M3: begin
        cost_c = bus_cost(BTCC_B_ACKN, REQ_RATIO, wterm, xterm);
        ext_c = 1'b1;
      end
      default: begin
        cost_c = BTCC_C_HIT;
      end
    endcase
    // Memory data transfers pay for the effective address
    case (REQ_KIND)
      BTCC_RD_BYTE, BTCC_RD_WORD, BTCC_WR_BYTE, BTCC_WR_WORD,
      BTCC_EPU_RD, BTCC_EPU_WR: begin
        cost_c = cost_c + amadd;
      end
      default: begin
        cost_c = cost_c;
      end
    endcase
    // A fault on a byte or word read or write overrides everything: short fixed cost, no transfer
    if (REQ_FAULT && (is_write || REQ_KIND == BTCC_RD_BYTE ||
                      REQ_KIND == BTCC_RD_WORD)) begin
      cost_c = BTCC_C_FAULT;
      ext_c = 1'b0;
    end
  end

  // A written byte still valid in cache forces a pipeline flush
  always_comb begin
    flush_c = is_write && !REQ_FAULT &&
              (REQ_HIT0 || (is_word && REQ_HIT1));
  end

  // Sequencer: load the cost, count it down, pulse at the end.
  // Requests during a transaction are ignored, not queued, since
  // the requester owns exactly one transaction at a time
  always_comb begin
    r_d = r_q;
    r_d.done = 1'b0;
    r_d.flush = 1'b0;
    r_d.trap = 1'b0;
    case (r_q.st)
      BTCC_IDLE: begin
        if (REQ) begin
          r_d.st = BTCC_RUN;
          r_d.cost = cost_c;
          r_d.cnt = cost_c - 8'h01;
          r_d.fl_pend = flush_c;
          r_d.tr_pend = REQ_FAULT && (is_write ||
                        REQ_KIND == BTCC_RD_BYTE ||
                        REQ_KIND == BTCC_RD_WORD);
          r_d.busy = 1'b1;
          r_d.ext = ext_c;
        end
      end
      BTCC_RUN: begin
        if (r_q.cnt == BTCC_CNT_RST) begin
          // Last cycle: report completion, flush or trap
          r_d.st = BTCC_IDLE;
          r_d.busy = 1'b0;
          r_d.ext = 1'b0;
          r_d.done = 1'b1;
          r_d.flush = r_q.fl_pend;
          r_d.trap = r_q.tr_pend;
          r_d.fl_pend = 1'b0;
          r_d.tr_pend = 1'b0;
        end else begin
          r_d.cnt = r_q.cnt - 8'h01;
        end
      end
      default: begin
        r_d.st = BTCC_IDLE;
        r_d.busy = 1'b0;
      end
    endcase
  end

  // State register, frozen while the enable is low
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      r_q <= '0;
    end else if (CE) begin
      r_q <= r_d;
    end
  end

  // Outputs straight from the state register
  assign BUSY = r_q.busy;
  assign DONE = r_q.done;
  assign COST = r_q.cost;
  assign FLUSH = r_q.flush;
  assign AV_TRAP = r_q.trap;
  assign EXT_CYCLE = r_q.ext;

endmodule // btcc_cost_timer

// File: btcc_cost_timer_assertions.sv
// Port-level checker for the bus transaction cycle cost timer
`timescale 1ns/1ps
module btcc_cost_timer_checker (
  // Clock, reset and enable
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CE,
  // Request
  input wire logic REQ,
  input wire btcc_pkg::btcc_kind_t REQ_KIND,
  input wire btcc_pkg::btcc_ratio_t REQ_RATIO,
  input wire logic [3:0] REQ_WAIT,
  input wire btcc_pkg::btcc_amode_t REQ_AMODE,
  input wire logic REQ_HIT0,
  input wire logic REQ_HIT1,
  input wire logic REQ_ADDR0,
  input wire logic REQ_BUS16,
  input wire logic REQ_FAULT,
  // Results
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic [7:0] COST,
  input wire logic FLUSH,
  input wire logic AV_TRAP,
  input wire logic EXT_CYCLE
);
  import btcc_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // A request is taken only while idle and enabled
  logic take;
  logic easy;
  logic [7:0] busy_cnt_q;
  assign take = CE && REQ && !BUSY;
  // Plain case: no fault and no address computation cycles
  assign easy = take && !REQ_FAULT && REQ_AMODE == BTCC_AM_IR;
  // Counts enabled busy cycles so the busy span can be tied to COST
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cnt_q <= 8'h00;
    end else if (!BUSY) begin
      busy_cnt_q <= 8'h00;
    end else if (CE) begin
      busy_cnt_q <= busy_cnt_q + 8'h01;
    end
  end
  property p_rd_hit;
    easy && REQ_KIND == BTCC_RD_BYTE && REQ_HIT0
      |=> COST == 8'h05 && !EXT_CYCLE;
  endproperty
  a_rd_hit: assert property (p_rd_hit)
    else $error("byte read hit cost wrong");
  property p_miss;
    easy && REQ_KIND == BTCC_RD_BYTE && !REQ_HIT0 && REQ_RATIO == BTCC_R1X
      |=> EXT_CYCLE && COST == 8'h08 + {4'h0, $past(REQ_WAIT)};
  endproperty
  a_miss: assert property (p_miss)
    else $error("byte read miss cost wrong");
  property p_uhh;
    easy && REQ_KIND == BTCC_RD_WORD && (REQ_ADDR0 || !REQ_BUS16)
      && REQ_HIT0 && REQ_HIT1 |=> COST == 8'h09;
  endproperty
  a_uhh: assert property (p_uhh)
    else $error("unaligned hit hit cost wrong");
  property p_align;
    easy && REQ_KIND == BTCC_RD_WORD && !REQ_ADDR0 && REQ_BUS16 && REQ_HIT0
      |=> COST == 8'h05;
  endproperty
  a_align: assert property (p_align)
    else $error("aligned word treated as unaligned");
  property p_fault;
    take && REQ_FAULT && REQ_KIND inside {BTCC_RD_BYTE, BTCC_RD_WORD,
      BTCC_WR_BYTE, BTCC_WR_WORD} |=> COST == 8'h04 && !EXT_CYCLE
      ##4 DONE && AV_TRAP;
  endproperty
  a_fault: assert property (p_fault)
    else $error("page fault not cut short with trap");
  property p_bx;
    take && !REQ_FAULT && REQ_AMODE == BTCC_AM_BX && REQ_HIT0
      && REQ_KIND == BTCC_RD_BYTE |=> COST == 8'h07;
  endproperty
  a_bx: assert property (p_bx)
    else $error("base index cycles not added");
  property p_wr_flush;
    easy && REQ_KIND == BTCC_WR_BYTE && REQ_HIT0
      |=> COST == 8'h05 ##5 DONE && FLUSH;
  endproperty
  a_wr_flush: assert property (p_wr_flush)
    else $error("cached byte write without flush");
  property p_busy_len;
    $fell(BUSY) |-> DONE && busy_cnt_q == COST;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy span differs from cost");
endmodule // btcc_cost_timer_checker

bind btcc_cost_timer btcc_cost_timer_checker u_chk (.CLOCK(CLOCK),
  .RST_B(RST_B), .CE(CE), .REQ(REQ), .REQ_KIND(REQ_KIND),
  .REQ_RATIO(REQ_RATIO), .REQ_WAIT(REQ_WAIT), .REQ_AMODE(REQ_AMODE),
  .REQ_HIT0(REQ_HIT0), .REQ_HIT1(REQ_HIT1), .REQ_ADDR0(REQ_ADDR0),
  .REQ_BUS16(REQ_BUS16), .REQ_FAULT(REQ_FAULT), .BUSY(BUSY), .DONE(DONE),
  .COST(COST), .FLUSH(FLUSH), .AV_TRAP(AV_TRAP), .EXT_CYCLE(EXT_CYCLE));

// File: btcc_bus_partner.sv
// Far-side model: bus clock source and wait state reporting
`timescale 1ns/1ps
module btcc_bus_partner (
  // Control from the bench
  input wire logic run,
  input wire logic is_io,
  input wire logic [3:0] bus_waits,
  // Bus clock and the waits that count
  output logic bus_clk,
  output logic [3:0] wait_cnt
);
  // Free phase against the processor clock; stands low when idle
  initial bus_clk = 1'b0;
  always #3.1 bus_clk = run ? ~bus_clk : 1'b0;
  // The built-in I/O wait state is not reported
  assign wait_cnt = (is_io && bus_waits != 4'h0) ?
    bus_waits - 4'h1 : bus_waits;
endmodule // btcc_bus_partner

// File: tb.sv
// Self-checking bench for the bus transaction cycle cost timer
`timescale 1ns/1ps
module tb;
  import btcc_pkg::*;
  logic clock = 1'b0;
  logic rst_b, ce, req, run, is_io, bus_clk;
  logic busy, done, flush, av_trap, ext_cycle;
  logic [6:0] flg; // hit0 hit1 addr0 bus16 fault fixed internal
  logic [3:0] tot, req_wait;
  logic [7:0] cost;
  btcc_kind_t kind;
  btcc_ratio_t ratio;
  btcc_amode_t amode;
  logic [31:0] lfsr = 32'h5959;
  logic [9:0] e;
  logic [9:0] exp_q[$]; // Expected cost, flush, trap
  int n_mismatch = 0, n_tests = 0, busy_n = 0;
  btcc_bus_partner u_partner (.run(run), .is_io(is_io), .bus_waits(tot),
    .bus_clk(bus_clk), .wait_cnt(req_wait));
  btcc_cost_timer u_dut (.CLOCK(clock), .RST_B(rst_b), .CE(ce),
    .BUS_CLK(bus_clk), .REQ(req), .REQ_KIND(kind), .REQ_RATIO(ratio),
    .REQ_WAIT(req_wait), .REQ_AMODE(amode), .REQ_HIT0(flg[6]),
    .REQ_HIT1(flg[5]), .REQ_ADDR0(flg[4]), .REQ_BUS16(flg[3]),
    .REQ_FAULT(flg[2]), .REQ_FIXED(flg[1]), .REQ_INTERNAL(flg[0]),
    .BUSY(busy), .DONE(done), .COST(cost), .FLUSH(flush),
    .AV_TRAP(av_trap), .EXT_CYCLE(ext_cycle));
  always #2 clock = ~clock;
  // Cost model; bus clock stopped, so the phase extra is at its top
  function automatic logic [9:0] model(input btcc_kind_t k,
      input logic [1:0] r, input int w, input logic [2:0] am,
      input logic [6:0] f);
    int miss[3] = '{8, 11, 16};
    int um1[3] = '{12, 15, 20};
    int umm[3] = '{15, 21, 31};
    int uwr[3] = '{9, 12, 17};
    int iord[3] = '{9, 13, 20};
    int ack0[3] = '{8, 13, 22};
    int ackn[3] = '{10, 15, 24};
    int ri, x, wt, a, c;
    logic wd, un, fl, tr;
    ri = (r == 2'h1) ? 1 : (r == 2'h2) ? 2 : 0;
    x = (ri == 2) ? 3 : ri;
    wt = w << ri;
    a = (am == 3'h6) ? 2 : (am >= 3'h2 && am <= 3'h5) ? 1 : 0;
    wd = (k == BTCC_RD_WORD) || (k == BTCC_WR_WORD);
    un = wd && (f[4] || !f[3]);
    fl = 1'b0;
    tr = f[2] && k <= BTCC_WR_WORD;
    case (k)
      BTCC_RD_BYTE, BTCC_RD_WORD: begin
        if (!un) c = f[6] ? 5 : miss[ri] + wt + x;
        else if (f[6] && f[5]) c = 9;
        else if (f[6] || f[5]) c = um1[ri] + wt + x;
        else c = umm[ri] + wt + 2 * x;
        c = c + a;
      end
      BTCC_WR_BYTE, BTCC_WR_WORD: begin
        if (!un) c = 5;
        else if (f[6] && ri == 0) c = (w <= 1) ? 10 : 9 + w;
        else c = uwr[ri] + wt + x;
        c = c + a;
        fl = f[6] || (wd && f[5]);
      end
      BTCC_IO_RD: c = f[0] ? 5 : iord[ri] + wt + x;
      BTCC_IO_WR: c = 5;
      BTCC_TEST_SET: c = f[1] ? 6 : miss[ri] + wt + x;
      BTCC_EPU_CPU: c = iord[ri] + wt + x;
      BTCC_EPU_WR: c = ackn[ri] + wt + x + a;
      BTCC_EPU_RD: c = miss[ri] + wt + x + a;
      BTCC_ACK_NMI: c = 4;
      BTCC_ACK_M0: c = ack0[ri] + wt + x;
      BTCC_ACK_M1, BTCC_ACK_M2, BTCC_ACK_M3: c = ackn[ri] + wt + x;
      default: c = miss[ri] + wt + x;
    endcase
    if (tr) c = 4; // Fault overrides every other cost
    return {c[7:0], fl && !tr, tr};
  endfunction
  function automatic logic [31:0] step(input logic [31:0] s);
    repeat (32) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held high through busy, so a retake would show up as extra
  task automatic go(input btcc_kind_t k, input logic [1:0] r,
      input logic [3:0] t, input logic [2:0] am, input logic [6:0] f);
    int n;
    kind = k;
    ratio = btcc_ratio_t'(r);
    amode = btcc_amode_t'(am);
    flg = f;
    tot = t;
    is_io = (k == BTCC_IO_RD) || (k == BTCC_IO_WR);
    n = (is_io && t != 4'h0) ? t - 1 : t;
    exp_q.push_back(model(k, r, n, am, f));
    req = 1'b1;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (!done && n < 120);
    if (!done) check(8'h00, 8'h01);
  endtask
  task automatic rnd(input int cnt, input logic slow);
    for (int i = 0; i < cnt; i++) begin
      lfsr = step(lfsr);
      go(btcc_kind_t'(5'(lfsr[31:16] % 16'd17)), slow ? 2'h0 : lfsr[1:0],
        lfsr[5:2], lfsr[8:6], lfsr[15:9] & {4'hf, lfsr[16], 2'h3});
    end
    req = 1'b0;
    @(negedge clock);
  endtask
  task automatic end_sim;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Monitor: each done pulse retires the oldest expectation
  always @(negedge clock) begin
    if (done) begin
      if (exp_q.size() == 0) begin
        check(8'hee, 8'h00);
      end else begin
        e = exp_q.pop_front();
        check(cost, e[9:2]);
        check({6'h00, flush, av_trap}, {6'h00, e[1:0]});
        check(8'(busy_n), e[9:2]);
        check({7'h00, ext_cycle}, 8'h00);
      end
    end
    busy_n = busy ? busy_n + 1 : 0;
  end
  // Watchdog sized well above the expected run length
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    end_sim;
  end
  initial begin
    {rst_b, req, run, is_io, flg, tot} = '0;
    ce = 1'b1;
    kind = BTCC_RD_BYTE;
    ratio = BTCC_R1X;
    amode = BTCC_AM_IR;
    repeat (20) @(negedge clock);
    rst_b = 1'b1;
    @(negedge clock);
    go(BTCC_RD_BYTE, 2'h0, 4'h0, 3'h0, 7'h40);
    go(BTCC_RD_BYTE, 2'h0, 4'h3, 3'h0, 7'h00);
    go(BTCC_RD_WORD, 2'h0, 4'h0, 3'h0, 7'h70);
    go(BTCC_RD_WORD, 2'h0, 4'h0, 3'h0, 7'h48);
    go(BTCC_RD_WORD, 2'h1, 4'h2, 3'h0, 7'h20);
    go(BTCC_RD_WORD, 2'h2, 4'h2, 3'h0, 7'h10);
    go(BTCC_WR_WORD, 2'h0, 4'h0, 3'h0, 7'h44);
    go(BTCC_RD_BYTE, 2'h0, 4'h0, 3'h6, 7'h40);
    go(BTCC_WR_BYTE, 2'h0, 4'h0, 3'h0, 7'h40);
    go(BTCC_WR_WORD, 2'h0, 4'h1, 3'h0, 7'h50);
    go(BTCC_WR_WORD, 2'h0, 4'h3, 3'h0, 7'h50);
    go(BTCC_IO_RD, 2'h2, 4'h0, 3'h0, 7'h01);
    go(BTCC_IO_RD, 2'h0, 4'h3, 3'h0, 7'h00);
    go(BTCC_EPU_WR, 2'h1, 4'h1, 3'h6, 7'h00);
    req = 1'b0;
    @(negedge clock);
    $display("test directed done");
    ce = 1'b0;
    req = 1'b1;
    repeat (3) @(negedge clock);
    check({7'h00, busy}, 8'h00);
    req = 1'b0;
    @(negedge clock);
    ce = 1'b1;
    $display("test enable done");
    rnd(200, 1'b0);
    $display("test random done");
    run = 1'b1;
    rnd(30, 1'b1);
    run = 1'b0;
    $display("test bus clock done");
    end_sim;
  end
endmodule // tb
